// File: hw/serial_command_line_discipline.sv
// line discipline between the serial port and the command parser
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module serial_command_line_discipline
  import line_discipline_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic line_ready_o,
  output logic error_post_o,
  output logic [15:0] error_code_o,
  output logic output_cmd_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [LINE_DEPTH-1:0][7:0] line_buf;
    logic [7:0] line_len;
    logic line_ready;
    logic [6:0] rd_idx;
    logic [TXQ_DEPTH-1:0][7:0] txq;
    logic [4:0] wr_ptr;
    logic [4:0] rd_ptr;
    logic [5:0] txq_cnt;
    logic [3:0][7:0] seq;
    logic [2:0] seq_cnt;
    logic [7:0] cfg;
    logic tx_enabled;
    logic xoff_seen;
    logic bang_pending;
    logic nak_pending;
    logic queue_loss;
    logic overrun;
    logic last_term;
    logic [7:0] last_term_chr;
    logic tx_start;
    logic [7:0] tx_byte;
    logic [7:0] rdata;
    logic err_post;
    logic [15:0] err_code;
    logic out_cmd;
  } ld_state_t;

  ld_state_t st;
  ld_state_t next_st;
  char_t rx_char;
  logic tx_ready;
  logic tx_line;

  function automatic logic is_term(input logic [7:0] c);
    is_term = (c == CHR_CR) || (c == CHR_LF);
  endfunction : is_term

  // ---------------------------------------------------------------
  // serial engines
  // ---------------------------------------------------------------
  serial_rx serial_rx_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .rxd_i(rxd_i),
    .char_o(rx_char)
  );

  serial_tx serial_tx_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(st.tx_start),
    .data_i(st.tx_byte),
    .ready_o(tx_ready),
    .txd_o(tx_line)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [7:0] c;
    logic echo;
    logic flow;
    logic push;
    logic [7:0] push_byte;
    logic [5:0] cnt;
    c = rx_char.data;
    echo = st.cfg[CFG_ECHO_BIT];
    flow = st.cfg[CFG_FLOW_BIT];
    push = 1'b0;
    push_byte = 8'h00;
    cnt = st.txq_cnt;
    next_st = st;
    next_st.tx_start = 1'b0;
    next_st.rdata = 8'h00;
    next_st.err_post = 1'b0;
    next_st.out_cmd = 1'b0;

    // register reads
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        REG_CONFIG: next_st.rdata = st.cfg;
        REG_STATUS:
        begin
          next_st.rdata[STS_LINE_READY_BIT] = st.line_ready;
          next_st.rdata[STS_TX_HALTED_BIT] = flow && !st.tx_enabled;
          next_st.rdata[STS_QUEUE_LOSS_BIT] = st.queue_loss;
          next_st.rdata[STS_OVERRUN_BIT] = st.overrun;
          next_st.rdata[STS_TXQ_FULL_BIT] = (st.txq_cnt == TXQ_FULL);
        end
        REG_LINE_LEN: next_st.rdata = st.line_len;
        REG_LINE_DATA:
        begin
          next_st.rdata = st.line_buf[st.rd_idx];
          next_st.rd_idx = st.rd_idx + 7'h01;
        end
        default: next_st.rdata = 8'h00;
      endcase
    end

    // register writes
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        REG_CONFIG: next_st.cfg = reg_wdata_i;
        REG_STATUS:
        begin
          if (reg_wdata_i[STS_QUEUE_LOSS_BIT])
            next_st.queue_loss = 1'b0;
          if (reg_wdata_i[STS_OVERRUN_BIT])
            next_st.overrun = 1'b0;
        end
        REG_LINE_INDEX: next_st.rd_idx = reg_wdata_i[6:0];
        REG_TX_DATA:
        begin
          push = 1'b1;
          push_byte = reg_wdata_i;
        end
        REG_CONTROL:
        begin
          if (reg_wdata_i[CTL_EXEC_OUTPUT_BIT])
            next_st.out_cmd = st.cfg[CFG_REMOTE_BIT];
          if (reg_wdata_i[CTL_LINE_DONE_BIT] && st.line_ready)
          begin
            next_st.line_ready = 1'b0;
            next_st.line_len = 8'h00;
            next_st.rd_idx = 7'h00;
            next_st.seq = {CHR_XON, CHR_PROMPT, CHR_LF, CHR_CR};
            // prompt and flow control each add a trailing character
            if (st.cfg[CFG_PROMPT_BIT])
            begin
              next_st.seq_cnt = flow ? 3'h4 : 3'h3;
            end
            else
            begin
              next_st.seq = {8'h00, 8'h00, CHR_LF, CHR_CR};
              if (flow)
                next_st.seq = {8'h00, CHR_XON, CHR_LF, CHR_CR};
              next_st.seq_cnt = flow ? 3'h3 : 3'h2;
            end
          end
        end
        default: ;
      endcase
    end

    // transmit queue drain, stalled while the host holds us off
    if (!st.tx_start && tx_ready && st.txq_cnt != 6'h00 && (st.tx_enabled || !flow))
    begin
      next_st.tx_start = 1'b1;
      next_st.tx_byte = st.txq[st.rd_ptr];
      next_st.rd_ptr = st.rd_ptr + 5'h01;
    end
    cnt = next_st.tx_start ? st.txq_cnt - 6'h01 : st.txq_cnt;

    // one push per cycle: software, then pending sequence, then markers
    if (!push && st.seq_cnt != 3'h0)
    begin
      push = 1'b1;
      push_byte = st.seq[0];
      next_st.seq = {8'h00, st.seq[3:1]};
      next_st.seq_cnt = st.seq_cnt - 3'h1;
    end
    else if (!push && st.nak_pending && cnt != TXQ_FULL)
    begin
      push = 1'b1;
      push_byte = CHR_NAK;
      next_st.nak_pending = 1'b0;
    end
    else if (!push && st.bang_pending && cnt == 6'h00 && tx_ready && !st.tx_start
             && !next_st.tx_start)
    begin
      push = 1'b1;
      push_byte = CHR_BANG;
      next_st.bang_pending = 1'b0;
    end

    if (push)
    begin
      if (cnt == TXQ_FULL)
      begin
        next_st.queue_loss = 1'b1;
        if (echo)
        begin
          next_st.nak_pending = 1'b1;
          next_st.err_post = 1'b1;
          next_st.err_code = QUEUE_LOSS_ERROR_CODE;
        end
      end
      else
      begin
        next_st.txq[st.wr_ptr] = push_byte;
        next_st.wr_ptr = st.wr_ptr + 5'h01;
        cnt = cnt + 6'h01;
      end
    end
    next_st.txq_cnt = cnt;

    // received characters, modes sampled as the character arrives
    if (rx_char.valid)
    begin
      next_st.last_term = 1'b0;
      if (c == CHR_CAN)
      begin
        next_st.line_len = 8'h00;
        next_st.line_ready = 1'b0;
        next_st.rd_idx = 7'h00;
        next_st.wr_ptr = 5'h00;
        next_st.rd_ptr = 5'h00;
        next_st.txq_cnt = 6'h00;
        next_st.seq_cnt = 3'h0;
        next_st.tx_start = 1'b0;
        next_st.bang_pending = 1'b0;
        next_st.nak_pending = 1'b0;
      end
      else if (c == CHR_ESC)
      begin
        next_st.line_len = 8'h00;
        next_st.line_ready = 1'b0;
        next_st.rd_idx = 7'h00;
        next_st.seq = {8'h00, 8'h00, CHR_LF, CHR_CR};
        next_st.seq_cnt = 3'h2;
      end
      else if (c == CHR_XON)
      begin
        if (flow)
        begin
          next_st.tx_enabled = 1'b1;
          if (st.xoff_seen)
          begin
            next_st.bang_pending = 1'b1;
            next_st.xoff_seen = 1'b0;
          end
        end
      end
      else if (c == CHR_XOFF)
      begin
        if (flow)
        begin
          next_st.tx_enabled = 1'b0;
          next_st.xoff_seen = 1'b1;
          next_st.err_post = 1'b1;
          next_st.err_code = QUEUE_LOSS_ERROR_CODE;
        end
      end
      else if (is_term(c))
      begin
        if (st.last_term && c != st.last_term_chr)
        begin
          // second half of a CR LF or LF CR pair: swallowed
          next_st.last_term = 1'b0;
        end
        else
        begin
          next_st.last_term = 1'b1;
          next_st.last_term_chr = c;
          if (st.line_ready)
            next_st.overrun = 1'b1;
          else
          begin
            if (st.line_len != LINE_FULL)
            begin
              next_st.line_buf[st.line_len[6:0]] = c;
              next_st.line_len = st.line_len + 8'h01;
            end
            next_st.line_ready = 1'b1;
            next_st.rd_idx = 7'h00;
          end
          if (flow)
          begin
            next_st.seq = {8'h00, 8'h00, CHR_CR, CHR_XOFF};
            next_st.seq_cnt = echo ? 3'h2 : 3'h1;
          end
          else if (echo)
          begin
            next_st.seq = {8'h00, 8'h00, 8'h00, c};
            next_st.seq_cnt = 3'h1;
          end
        end
      end
      else if (c == CHR_BS)
      begin
        if (!st.line_ready && st.line_len != 8'h00
            && !is_term(st.line_buf[st.line_len[6:0] - 7'h01]))
          next_st.line_len = st.line_len - 8'h01;
        if (echo)
        begin
          next_st.seq = {8'h00, CHR_BS, CHR_SPACE, CHR_BS};
          next_st.seq_cnt = 3'h3;
        end
      end
      else if (c >= CHR_FIRST_PRINT)
      begin
        if (st.line_ready || st.line_len == LINE_FULL)
          next_st.overrun = 1'b1;
        else
        begin
          next_st.line_buf[st.line_len[6:0]] = c;
          next_st.line_len = st.line_len + 8'h01;
        end
        if (echo)
        begin
          next_st.seq = {8'h00, 8'h00, 8'h00, c};
          next_st.seq_cnt = 3'h1;
        end
      end
      // remaining control characters fall through untouched
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.cfg <= CFG_RESET;
      st.tx_enabled <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign txd_o = tx_line;
  assign reg_rdata_o = st.rdata;
  assign line_ready_o = st.line_ready;
  assign error_post_o = st.err_post;
  assign error_code_o = st.err_code;
  assign output_cmd_o = st.out_cmd;

endmodule : serial_command_line_discipline
`default_nettype wire

// File: common/line_discipline_pkg.sv
// constants and types for the serial command line discipline
package line_discipline_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_RATE = 115200;
  localparam logic [10:0] BIT_CYCLES = 11'(CLK_HZ / BAUD_RATE);
  localparam logic [10:0] HALF_BIT_CYCLES = 11'(CLK_HZ / BAUD_RATE / 2);
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // ---------------------------------------------------------------
  // characters
  // ---------------------------------------------------------------
  localparam logic [7:0] CHR_BS = 8'h08;
  localparam logic [7:0] CHR_LF = 8'h0A;
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_XON = 8'h11;
  localparam logic [7:0] CHR_XOFF = 8'h13;
  localparam logic [7:0] CHR_NAK = 8'h15;
  localparam logic [7:0] CHR_CAN = 8'h18;
  localparam logic [7:0] CHR_ESC = 8'h1B;
  localparam logic [7:0] CHR_SPACE = 8'h20;
  localparam logic [7:0] CHR_BANG = 8'h21;
  localparam logic [7:0] CHR_PROMPT = 8'h3E;
  localparam logic [7:0] CHR_FIRST_PRINT = 8'h20;

  // ---------------------------------------------------------------
  // buffer sizes
  // ---------------------------------------------------------------
  localparam int LINE_DEPTH = 128;
  localparam logic [7:0] LINE_FULL = 8'h80;
  localparam int TXQ_DEPTH = 32;
  localparam logic [5:0] TXQ_FULL = 6'h20;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_LINE_LEN = 4'h2;
  localparam logic [3:0] REG_LINE_INDEX = 4'h3;
  localparam logic [3:0] REG_LINE_DATA = 4'h4;
  localparam logic [3:0] REG_TX_DATA = 4'h5;
  localparam logic [3:0] REG_CONTROL = 4'h6;

  localparam int CFG_ECHO_BIT = 0;
  localparam int CFG_PROMPT_BIT = 1;
  localparam int CFG_FLOW_BIT = 2;
  localparam int CFG_REMOTE_BIT = 3;
  // flow control on, prompt and echo off, local mode
  localparam logic [7:0] CFG_RESET = 8'h04;

  localparam int STS_LINE_READY_BIT = 0;
  localparam int STS_TX_HALTED_BIT = 1;
  localparam int STS_QUEUE_LOSS_BIT = 2;
  localparam int STS_OVERRUN_BIT = 3;
  localparam int STS_TXQ_FULL_BIT = 4;

  localparam int CTL_LINE_DONE_BIT = 0;
  localparam int CTL_EXEC_OUTPUT_BIT = 1;

  // -400, two's complement
  localparam logic [15:0] QUEUE_LOSS_ERROR_CODE = 16'hFE70;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } char_t;

  typedef enum logic [1:0] {PH_IDLE, PH_START, PH_DATA, PH_STOP} serial_phase_t;

endpackage : line_discipline_pkg

// File: hw/serial_rx.sv
// 8N1 serial receiver with input synchroniser
`timescale 1ns/1ps
`default_nettype none
module serial_rx
  import line_discipline_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic rxd_i,
  output char_t char_o
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    serial_phase_t phase;
    logic [10:0] cnt;
    logic [2:0] idx;
    logic [7:0] shift;
    char_t out;
  } rx_state_t;

  rx_state_t st;
  rx_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.sync1 = rxd_i;
    next_st.sync2 = st.sync1;
    next_st.out.valid = 1'b0;
    case (st.phase)
      PH_IDLE:
      begin
        if (!st.sync2)
        begin
          next_st.phase = PH_START;
          next_st.cnt = HALF_BIT_CYCLES;
        end
      end
      PH_START:
      begin
        if (st.cnt == 11'h000)
        begin
          next_st.phase = st.sync2 ? PH_IDLE : PH_DATA;
          next_st.cnt = BIT_CYCLES;
          next_st.idx = 3'h0;
        end
        else
          next_st.cnt = st.cnt - 11'h001;
      end
      PH_DATA:
      begin
        if (st.cnt == 11'h000)
        begin
          next_st.shift = {st.sync2, st.shift[7:1]};
          next_st.cnt = BIT_CYCLES;
          if (st.idx == LAST_DATA_BIT)
            next_st.phase = PH_STOP;
          else
            next_st.idx = st.idx + 3'h1;
        end
        else
          next_st.cnt = st.cnt - 11'h001;
      end
      PH_STOP:
      begin
        if (st.cnt == 11'h000)
        begin
          // a missing stop bit drops the character
          next_st.out.valid = st.sync2;
          next_st.out.data = st.shift;
          next_st.phase = PH_IDLE;
        end
        else
          next_st.cnt = st.cnt - 11'h001;
      end
      default:
        next_st.phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.sync1 <= 1'b1;
      st.sync2 <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign char_o = st.out;

endmodule : serial_rx
`default_nettype wire

// File: hw/serial_tx.sv
// 8N1 serial transmitter
`timescale 1ns/1ps
`default_nettype none
module serial_tx
  import line_discipline_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] data_i,
  output logic ready_o,
  output logic txd_o
);

  typedef struct packed {
    serial_phase_t phase;
    logic [10:0] cnt;
    logic [2:0] idx;
    logic [7:0] shift;
    logic line;
  } tx_state_t;

  tx_state_t st;
  tx_state_t next_st;

  always_comb
  begin
    next_st = st;
    case (st.phase)
      PH_IDLE:
      begin
        next_st.line = 1'b1;
        if (start_i)
        begin
          next_st.shift = data_i;
          next_st.line = 1'b0;
          next_st.cnt = BIT_CYCLES;
          next_st.phase = PH_START;
        end
      end
      PH_START, PH_DATA:
      begin
        if (st.cnt == 11'h000)
        begin
          next_st.cnt = BIT_CYCLES;
          if (st.phase == PH_DATA && st.idx == LAST_DATA_BIT)
          begin
            next_st.line = 1'b1;
            next_st.phase = PH_STOP;
          end
          else
          begin
            next_st.line = st.shift[0];
            next_st.shift = {1'b0, st.shift[7:1]};
            next_st.idx = (st.phase == PH_START) ? 3'h0 : st.idx + 3'h1;
            next_st.phase = PH_DATA;
          end
        end
        else
          next_st.cnt = st.cnt - 11'h001;
      end
      PH_STOP:
      begin
        if (st.cnt == 11'h000)
          next_st.phase = PH_IDLE;
        else
          next_st.cnt = st.cnt - 11'h001;
      end
      default:
        next_st.phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.line <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign ready_o = (st.phase == PH_IDLE);
  assign txd_o = st.line;

endmodule : serial_tx
`default_nettype wire

// File: dv/line_discipline_monitor.sv
// port assertions for the serial command line discipline
`timescale 1ns/1ps
`default_nettype none
module line_discipline_monitor
  import line_discipline_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic rxd_i,
  input wire logic txd_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic line_ready_o,
  input wire logic error_post_o,
  input wire logic [15:0] error_code_o,
  input wire logic output_cmd_o
);
  // ------
  // shadow of the mode register
  // ------
  logic [7:0] cfg;
  logic [3:0] mode;
  logic wr_ctl, wr_exec, remote;
  assign mode = cfg[3:0];
  assign remote = cfg[CFG_REMOTE_BIT];
  assign wr_ctl = reg_wr_i && reg_addr_i == REG_CONTROL;
  assign wr_exec = wr_ctl && reg_wdata_i[CTL_EXEC_OUTPUT_BIT];
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cfg <= CFG_RESET;
    else if (reg_wr_i && reg_addr_i == REG_CONFIG)
      cfg <= reg_wdata_i;
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_cfg_read;
    reg_rd_i && reg_addr_i == REG_CONFIG |=> reg_rdata_o[3:0] == $past(mode);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("mode readback wrong");
  property p_rd_quiet;
    !reg_rd_i |=> reg_rdata_o == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data without read");
  property p_sts_ready;
    reg_rd_i && reg_addr_i == REG_STATUS |=>
      reg_rdata_o[STS_LINE_READY_BIT] == $past(line_ready_o);
  endproperty
  a_sts_ready: assert property (p_sts_ready) else $error("status ready bit wrong");
  property p_done_clears;
    wr_ctl && reg_wdata_i[CTL_LINE_DONE_BIT] && line_ready_o |=> !line_ready_o;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("line not released");
  property p_exec_gate;
    wr_exec |=> output_cmd_o == $past(remote);
  endproperty
  a_exec_gate: assert property (p_exec_gate) else $error("output command gating");
  property p_exec_cause;
    output_cmd_o |-> $past(wr_exec);
  endproperty
  a_exec_cause: assert property (p_exec_cause) else $error("stray output command");
  property p_err_pulse;
    error_post_o |=> !error_post_o;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error post too long");
  property p_err_code;
    error_post_o |=> (error_code_o == QUEUE_LOSS_ERROR_CODE) [*2];
  endproperty
  a_err_code: assert property (p_err_code) else $error("error code wrong");

  c_line: cover property ($rose(line_ready_o));
  c_err: cover property (error_post_o);
  c_cmd: cover property (output_cmd_o);
endmodule : line_discipline_monitor

bind serial_command_line_discipline line_discipline_monitor line_discipline_monitor_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .rxd_i(rxd_i), .txd_o(txd_o),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .line_ready_o(line_ready_o),
  .error_post_o(error_post_o), .error_code_o(error_code_o), .output_cmd_o(output_cmd_o)
);
`default_nettype wire

// File: dv/serial_host_model.sv
// host side of the serial port: sends characters, collects replies
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
  import line_discipline_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic txd_i,
  output var logic rxd_o
);
  logic [7:0] got[$];
  logic [7:0] b;
  logic held;
  initial
  begin
    rxd_o = 1'b1;
    held = 1'b0;
  end
  // 8N1 frame, lsb first; holds off while paused by the device
  task automatic send(input logic [7:0] c);
    while (held)
      @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    rxd_o <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT_CYCLES) @(posedge ref_clk_i);
      rxd_o <= (i == 8) | c[i[2:0]];
    end
    repeat (BIT_CYCLES) @(posedge ref_clk_i);
  endtask : send
  // decode device bytes at bit centres; bad stop bit gives unknown
  always
  begin
    @(negedge txd_i);
    repeat (HALF_BIT_CYCLES) @(posedge ref_clk_i);
    if (txd_i === 1'b0)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES) @(posedge ref_clk_i);
        b[i] = txd_i;
      end
      repeat (BIT_CYCLES) @(posedge ref_clk_i);
      if (txd_i !== 1'b1)
        b = 8'hxx;
      got.push_back(b);
      held = (b === CHR_XOFF) ? 1'b1 : (b === CHR_XON) ? 1'b0 : held;
    end
  end
endmodule : serial_host_model
`default_nettype wire

// File: dv/serial_command_line_discipline_tb.sv
// self-checking bench for the serial command line discipline
`timescale 1ns/1ps
`default_nettype none
module serial_command_line_discipline_tb
  import line_discipline_pkg::*;
;
  logic clk, rst, rxd, txd, wr, rd, line_ready, err_post, out_cmd;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, c, ctl, d;
  logic [15:0] err_code;
  int n_errors, n_compared, n_posts, n_cmds;
  logic [7:0] tq [32];

  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    if (err_post === 1'b1)
      n_posts++;
    if (out_cmd === 1'b1)
      n_cmds++;
  end

  serial_command_line_discipline serial_command_line_discipline_i (
    .ref_clk_i(clk), .rst_i(rst), .rxd_i(rxd), .txd_o(txd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .line_ready_o(line_ready), .error_post_o(err_post), .error_code_o(err_code),
    .output_cmd_o(out_cmd)
  );
  serial_host_model serial_host_model_i (.ref_clk_i(clk), .txd_i(txd), .rxd_o(rxd));

  // ------
  // checking and bus tasks
  // ------
  task automatic wrap_up();
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  // next byte seen by the host, bounded wait
  task automatic chk_tx(input logic [7:0] e);
    int w;
    logic [7:0] g;
    w = 0;
    g = 8'hxx;
    while (serial_host_model_i.got.size() == 0 && w < 40000)
    begin
      @(posedge clk);
      w++;
    end
    if (serial_host_model_i.got.size() != 0)
      g = serial_host_model_i.got.pop_front();
    chk(g, e);
  endtask : chk_tx

  initial
  begin
    // the scenarios need about 60k cycles at this baud rate
    repeat (90000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  // ------
  // main sequence
  // ------
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    void'($urandom(90686));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(REG_CONFIG, d);
    chk(d, CFG_RESET);
    rd_reg(4'hF, d);
    chk(d, 8'h00);
    wr_reg(REG_CONTROL, 8'h02);
    wr_reg(REG_CONFIG, 8'h0D);
    rd_reg(REG_CONFIG, d);
    chk(d[3:0], 4'hD);
    wr_reg(REG_CONTROL, 8'h02);
    @(posedge clk);
    #1 chk(16'(n_cmds), 16'h0001);
    c = 8'h21 + 8'($urandom_range(93));
    do
      ctl = 8'($urandom_range(31));
    while (ctl inside {CHR_BS, CHR_LF, CHR_CR, CHR_XON, CHR_XOFF, CHR_CAN, CHR_ESC});
    // one-character line, well within the 128-character line buffer limit
    serial_host_model_i.send(c);
    serial_host_model_i.send(ctl);
    serial_host_model_i.send(CHR_BS);
    serial_host_model_i.send(CHR_CR);
    serial_host_model_i.send(CHR_LF);
    chk(line_ready, 1'b1);
    rd_reg(REG_LINE_LEN, d);
    chk(d, 8'h01);
    wr_reg(REG_LINE_INDEX, 8'h00);
    rd_reg(REG_LINE_DATA, d);
    chk(d, CHR_CR);
    chk_tx(c);
    chk_tx(CHR_BS);
    chk_tx(CHR_SPACE);
    chk_tx(CHR_BS);
    chk_tx(CHR_XOFF);
    chk_tx(CHR_CR);
    wr_reg(REG_CONTROL, 8'h01);
    #1 chk(line_ready, 1'b0);
    chk_tx(CHR_CR);
    chk_tx(CHR_LF);
    chk_tx(CHR_XON);
    serial_host_model_i.send(CHR_XOFF);
    chk(16'(n_posts), 16'h0001);
    chk(err_code, QUEUE_LOSS_ERROR_CODE);
    rd_reg(REG_STATUS, d);
    chk(d[STS_TX_HALTED_BIT], 1'b1);
    serial_host_model_i.send(CHR_XON);
    chk_tx(CHR_BANG);
    rd_reg(REG_STATUS, d);
    chk(d[STS_TX_HALTED_BIT], 1'b0);
    // host verifies the echo, then resyncs with escape
    serial_host_model_i.send(c);
    chk_tx(c);
    serial_host_model_i.send(CHR_ESC);
    chk_tx(CHR_CR);
    chk_tx(CHR_LF);
    rd_reg(REG_LINE_LEN, d);
    chk(d, 8'h00);
    // halted queue filled by software, so the next echo is lost
    serial_host_model_i.send(CHR_XOFF);
    for (int i = 0; i < 32; i++)
    begin
      tq[i] = {1'b1, 7'($urandom)};
      wr_reg(REG_TX_DATA, tq[i]);
    end
    serial_host_model_i.send(c);
    chk(16'(n_posts), 16'h0003);
    rd_reg(REG_STATUS, d);
    chk(d[STS_QUEUE_LOSS_BIT], 1'b1);
    serial_host_model_i.send(CHR_XON);
    for (int i = 0; i < 32; i++)
      chk_tx(tq[i]);
    chk_tx(CHR_NAK);
    chk_tx(CHR_BANG);
    // cancel empties the line and the halted transmit queue
    serial_host_model_i.send(CHR_XOFF);
    wr_reg(REG_TX_DATA, {1'b1, 7'($urandom)});
    serial_host_model_i.send(c);
    serial_host_model_i.send(CHR_CAN);
    rd_reg(REG_LINE_LEN, d);
    chk(d, 8'h00);
    serial_host_model_i.send(CHR_XON);
    chk_tx(CHR_BANG);
    // echo off, prompt on: terminator answered by XOFF alone
    wr_reg(REG_CONFIG, 8'h0E);
    serial_host_model_i.send(c);
    serial_host_model_i.send(CHR_LF);
    chk_tx(CHR_XOFF);
    wr_reg(REG_LINE_INDEX, 8'h01);
    rd_reg(REG_LINE_DATA, d);
    chk(d, CHR_LF);
    wr_reg(REG_CONTROL, 8'h01);
    chk_tx(CHR_CR);
    chk_tx(CHR_LF);
    chk_tx(CHR_PROMPT);
    chk_tx(CHR_XON);
    wrap_up();
  end
endmodule : serial_command_line_discipline_tb
`default_nettype wire
